//--- hw/flag_bank.sv
// Status flag bank of serial ports, counters and print/rewrite, over AXI4-Lite
//
// Functional notes
// RULE1: First port mode flag is one in general-purpose mode, zero in command or link mode.
// RULE2: Print busy flag is one while a print runs and zero otherwise.
// RULE3: Rewrite done flag is one for only the scan after an online rewrite completes.
// RULE4: First port error flag sets on a transmission error.
// RULE5: First port error flag clears on a transmit-message request.
// RULE6: Receive-done flags of first and tool port set on terminator in general mode.
// RULE7: Transmit-done flags of first and tool port set when general transmission completes.
// RULE8: Transmit-done flags clear when a new general transmission is requested.
// RULE9: Each of four counter flags is one while a counter or pulse instruction runs there.
// RULE10: Flags may change within a scan; software must not assume they hold a scan.
// RULE11: Tool port mode flag is one in general mode and zero in computer link mode.
// RULE12: First port link flag is one while the port runs the controller link.
// RULE13: Second port mode flag is one in general mode and zero in command mode.
// RULE14: Message ready flag is zero while a send/receive runs and one when one may issue.
// RULE15: Message end flag is one after an abnormality in send/receive and zero otherwise.
// RULE16: On abnormality the error code and end code are stored in their own words.
// RULE17: All flags are read-only; bus writes leave them unchanged.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module flag_bank
	import flag_bank_pkg::*;
#(
	parameter int NUM_COUNTERS = 4
)
(
	input wire logic aclk, // Clock, 250 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic scan_start, // Pulse at the start of each scan
	input wire logic rewrite_complete, // Pulse when an online rewrite finishes
	input wire logic print_active, // Print in progress
	input wire flag_bank_pkg::port_mode_t first_serial_port_mode, // First port mode
	input wire flag_bank_pkg::port_mode_t tool_mode, // Tool port mode
	input wire flag_bank_pkg::port_mode_t second_serial_port_mode, // Second port mode
	input wire flag_bank_pkg::port_events_t first_serial_port_events, // First port event pulses
	input wire flag_bank_pkg::port_events_t tool_events, // Tool port event pulses
	input wire logic [NUM_COUNTERS-1:0] counter_active, // Counter or pulse instruction running
	input wire flag_bank_pkg::msg_status_t first_serial_port_msg, // Message instruction status
	input wire logic first_serial_port_msg_done, // Pulse when a message instruction ends
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	import flag_bank_pkg::*;

	// ****************************************
	// Flag state
	// ****************************************
	logic rewrite_pending_reg;
	logic rewrite_done_reg;
	logic first_serial_port_error_reg;
	logic first_serial_port_rx_done_reg;
	logic first_serial_port_tx_done_reg;
	logic tool_rx_done_reg;
	logic tool_tx_done_reg;
	logic msg_end_reg;
	logic [15:0] error_code_reg;
	logic [15:0] end_code_reg;
	logic [31:0] scratch_reg;
	logic [31:0] flags_word;

	// Sticky event flag: set wins over clear
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	// Rewrite done lasts from one scan start to the next
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rewrite_pending_reg <= 1'b0;
			rewrite_done_reg <= 1'b0;
		end
		else
		begin
			if (scan_start)
			begin
				rewrite_done_reg <= rewrite_pending_reg | rewrite_complete; // RULE3
				rewrite_pending_reg <= 1'b0;
			end
			else if (rewrite_complete)
				rewrite_pending_reg <= 1'b1;
		end
	end

	// Done events only count in general mode; error events count in every mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			first_serial_port_error_reg <= 1'b0;
			first_serial_port_rx_done_reg <= 1'b0;
			first_serial_port_tx_done_reg <= 1'b0;
			tool_rx_done_reg <= 1'b0;
			tool_tx_done_reg <= 1'b0;
		end
		else
		begin
			first_serial_port_error_reg <= sticky(first_serial_port_error_reg, first_serial_port_events.tx_error,
				first_serial_port_events.tx_request); // RULE4 RULE5
			first_serial_port_rx_done_reg <= first_serial_port_rx_done_reg |
				(first_serial_port_events.rx_terminator && first_serial_port_mode == MODE_GENERAL); // RULE6
			first_serial_port_tx_done_reg <= sticky(first_serial_port_tx_done_reg,
				first_serial_port_events.tx_complete && first_serial_port_mode == MODE_GENERAL,
				first_serial_port_events.tx_request && first_serial_port_mode == MODE_GENERAL); // RULE7 RULE8
			tool_rx_done_reg <= tool_rx_done_reg |
				(tool_events.rx_terminator && tool_mode == MODE_GENERAL); // RULE6
			tool_tx_done_reg <= sticky(tool_tx_done_reg,
				tool_events.tx_complete && tool_mode == MODE_GENERAL,
				tool_events.tx_request && tool_mode == MODE_GENERAL); // RULE7 RULE8
		end
	end

	// Message result captured when the instruction ends
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			msg_end_reg <= 1'b0;
			error_code_reg <= 16'h0000;
			end_code_reg <= 16'h0000;
		end
		else if (first_serial_port_msg_done)
		begin
			msg_end_reg <= first_serial_port_msg.abnormal; // RULE15
			if (first_serial_port_msg.abnormal)
			begin
				error_code_reg <= first_serial_port_msg.error_code; // RULE16
				end_code_reg <= first_serial_port_msg.end_code; // RULE16
			end
		end
	end

	// Level flags follow their sources directly, so may change mid-scan
	always_comb
	begin
		flags_word = RESET_WORD;
		flags_word[BIT_FIRST_SERIAL_PORT_MODE] = (first_serial_port_mode == MODE_GENERAL); // RULE1 RULE10
		flags_word[BIT_PRINT_BUSY] = print_active; // RULE2
		flags_word[BIT_REWRITE_DONE] = rewrite_done_reg;
		flags_word[BIT_FIRST_SERIAL_PORT_ERROR] = first_serial_port_error_reg;
		flags_word[BIT_FIRST_SERIAL_PORT_RX_DONE] = first_serial_port_rx_done_reg;
		flags_word[BIT_FIRST_SERIAL_PORT_TX_DONE] = first_serial_port_tx_done_reg;
		for (int i = 0; i < NUM_COUNTERS; i++)
			flags_word[BIT_COUNTER0 + i] = counter_active[i]; // RULE9
		flags_word[BIT_TOOL_RX_DONE] = tool_rx_done_reg;
		flags_word[BIT_TOOL_TX_DONE] = tool_tx_done_reg;
		flags_word[BIT_TOOL_MODE] = (tool_mode == MODE_GENERAL); // RULE11
		flags_word[BIT_FIRST_SERIAL_PORT_LINK] = (first_serial_port_mode == MODE_LINK); // RULE12
		flags_word[BIT_SECOND_SERIAL_PORT_MODE] = (second_serial_port_mode == MODE_GENERAL); // RULE13
		flags_word[BIT_FIRST_SERIAL_PORT_MSG_READY] = ~first_serial_port_msg.busy; // RULE14
		flags_word[BIT_FIRST_SERIAL_PORT_MSG_END] = msg_end_reg;
	end

	// ****************************************
	// AXI4-Lite write side
	// ****************************************
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;

	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			scratch_reg <= RESET_WORD;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (aw_held_reg && w_held_reg)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Flag words ignore writes; only the scratch word stores
				if (awaddr_reg[7:2] == OFS_SCRATCH[7:2])
				begin
					for (int b = 0; b < 4; b++)
						if (wstrb_reg[b])
							scratch_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
					s_axi_bresp <= RESP_OKAY;
				end
				else if (awaddr_reg[7:2] <= OFS_END_CODE[7:2])
					s_axi_bresp <= RESP_OKAY; // RULE17
				else
					s_axi_bresp <= RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// AXI4-Lite read side
	// ****************************************
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RESET_WORD;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr[7:2])
				OFS_FLAGS[7:2]: s_axi_rdata <= flags_word;
				OFS_ERROR_CODE[7:2]: s_axi_rdata <= {16'h0000, error_code_reg};
				OFS_END_CODE[7:2]: s_axi_rdata <= {16'h0000, end_code_reg};
				OFS_SCRATCH[7:2]: s_axi_rdata <= scratch_reg;
				default:
				begin
					s_axi_rdata <= RESET_WORD;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// Assertions
	// ****************************************
	logic flags_read;
	assign flags_read = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == OFS_FLAGS[7:2];

	property p_rewrite_one_scan;
		@(posedge aclk) disable iff (!aresetn)
		(scan_start && rewrite_done_reg) |=> !rewrite_done_reg || $past(rewrite_pending_reg) || $past(rewrite_complete);
	endproperty
	a_rewrite_one_scan: assert property (p_rewrite_one_scan) else $error("rewrite flag held past scan"); // RULE3

	property p_error_set;
		@(posedge aclk) disable iff (!aresetn)
		first_serial_port_events.tx_error |=> first_serial_port_error_reg;
	endproperty
	a_error_set: assert property (p_error_set) else $error("error flag not set"); // RULE4

	property p_error_clear;
		@(posedge aclk) disable iff (!aresetn)
		(first_serial_port_events.tx_request && !first_serial_port_events.tx_error) |=> !first_serial_port_error_reg;
	endproperty
	a_error_clear: assert property (p_error_clear) else $error("error flag not cleared"); // RULE5

	property p_rx_done;
		@(posedge aclk) disable iff (!aresetn)
		(tool_events.rx_terminator && tool_mode == MODE_GENERAL) |=> tool_rx_done_reg;
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("rx done not set"); // RULE6

	property p_tx_done;
		@(posedge aclk) disable iff (!aresetn)
		(first_serial_port_events.tx_complete && first_serial_port_mode == MODE_GENERAL) |=> first_serial_port_tx_done_reg;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("tx done not set"); // RULE7

	property p_tx_clear;
		@(posedge aclk) disable iff (!aresetn)
		(first_serial_port_events.tx_request && !first_serial_port_events.tx_complete && first_serial_port_mode == MODE_GENERAL)
			|=> !first_serial_port_tx_done_reg;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx done not cleared"); // RULE8

	property p_msg_codes;
		@(posedge aclk) disable iff (!aresetn)
		(first_serial_port_msg_done && first_serial_port_msg.abnormal) |=>
			msg_end_reg && error_code_reg == $past(first_serial_port_msg.error_code)
			&& end_code_reg == $past(first_serial_port_msg.end_code);
	endproperty
	a_msg_codes: assert property (p_msg_codes) else $error("message codes not stored"); // RULE15 RULE16

	property p_read_only;
		@(posedge aclk) disable iff (!aresetn)
		(aw_held_reg && w_held_reg) |=> $stable(error_code_reg) || $past(first_serial_port_msg_done);
	endproperty
	a_read_only: assert property (p_read_only) else $error("write changed a flag word"); // RULE17

	property p_read_answer;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_first_serial_port_mode;
		@(posedge aclk) disable iff (!aresetn)
		flags_read |=> s_axi_rdata[BIT_FIRST_SERIAL_PORT_MODE] == ($past(first_serial_port_mode) == MODE_GENERAL)
			&& s_axi_rdata[BIT_FIRST_SERIAL_PORT_LINK] == ($past(first_serial_port_mode) == MODE_LINK);
	endproperty
	a_first_serial_port_mode: assert property (p_first_serial_port_mode) else $error("mode flag wrong"); // RULE1 RULE12

	property p_port_modes;
		@(posedge aclk) disable iff (!aresetn)
		flags_read |=> s_axi_rdata[BIT_TOOL_MODE] == ($past(tool_mode) == MODE_GENERAL)
			&& s_axi_rdata[BIT_SECOND_SERIAL_PORT_MODE] == ($past(second_serial_port_mode) == MODE_GENERAL);
	endproperty
	a_port_modes: assert property (p_port_modes) else $error("mode flag wrong"); // RULE11 RULE13

	property p_levels;
		@(posedge aclk) disable iff (!aresetn)
		flags_read |=> s_axi_rdata[BIT_PRINT_BUSY] == $past(print_active)
			&& s_axi_rdata[BIT_COUNTER0 +: NUM_COUNTERS] == $past(counter_active)
			&& s_axi_rdata[BIT_FIRST_SERIAL_PORT_MSG_READY] == !$past(first_serial_port_msg.busy);
	endproperty
	a_levels: assert property (p_levels) else $error("level flag wrong"); // RULE2 RULE9 RULE14

	property p_rewrite_set;
		@(posedge aclk) disable iff (!aresetn)
		(scan_start && (rewrite_pending_reg || rewrite_complete)) |=> rewrite_done_reg;
	endproperty
	a_rewrite_set: assert property (p_rewrite_set) else $error("rewrite flag not set"); // RULE3

	property p_rewrite_hold;
		@(posedge aclk) disable iff (!aresetn)
		!scan_start |=> $stable(rewrite_done_reg);
	endproperty
	a_rewrite_hold: assert property (p_rewrite_hold) else $error("rewrite flag moved mid-scan"); // RULE3

	property p_rx_first_serial_port;
		@(posedge aclk) disable iff (!aresetn)
		(first_serial_port_events.rx_terminator && first_serial_port_mode == MODE_GENERAL) |=> first_serial_port_rx_done_reg;
	endproperty
	a_rx_first_serial_port: assert property (p_rx_first_serial_port) else $error("rx done not set"); // RULE6

	property p_tool_tx;
		@(posedge aclk) disable iff (!aresetn)
		(tool_events.tx_complete && tool_mode == MODE_GENERAL) |=> tool_tx_done_reg;
	endproperty
	a_tool_tx: assert property (p_tool_tx) else $error("tx done not set"); // RULE7

	property p_msg_end_clear;
		@(posedge aclk) disable iff (!aresetn)
		(first_serial_port_msg_done && !first_serial_port_msg.abnormal) |=> !msg_end_reg;
	endproperty
	a_msg_end_clear: assert property (p_msg_end_clear) else $error("end flag not cleared"); // RULE15

	c_rewrite: cover property (@(posedge aclk) disable iff (!aresetn) rewrite_done_reg);
	c_msg_error: cover property (@(posedge aclk) disable iff (!aresetn) first_serial_port_msg_done && first_serial_port_msg.abnormal);
	c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
	c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
	c_rx_done: cover property (@(posedge aclk) disable iff (!aresetn) first_serial_port_rx_done_reg && tool_rx_done_reg);

endmodule

`default_nettype wire

//--- inc/flag_bank_pkg.sv
// Package for the serial port status flag bank
package flag_bank_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_ERROR_CODE = 8'h04;
	localparam logic [7:0] OFS_END_CODE = 8'h08;
	localparam logic [7:0] OFS_SCRATCH = 8'h0C;

	// ****************************************
	// Field positions inside the flag word
	// ****************************************
	localparam int BIT_FIRST_SERIAL_PORT_MODE = 0;
	localparam int BIT_PRINT_BUSY = 1;
	localparam int BIT_REWRITE_DONE = 2;
	localparam int BIT_FIRST_SERIAL_PORT_ERROR = 3;
	localparam int BIT_FIRST_SERIAL_PORT_RX_DONE = 4;
	localparam int BIT_FIRST_SERIAL_PORT_TX_DONE = 5;
	localparam int BIT_COUNTER0 = 6;
	localparam int BIT_TOOL_RX_DONE = 10;
	localparam int BIT_TOOL_TX_DONE = 11;
	localparam int BIT_TOOL_MODE = 12;
	localparam int BIT_FIRST_SERIAL_PORT_LINK = 13;
	localparam int BIT_SECOND_SERIAL_PORT_MODE = 14;
	localparam int BIT_FIRST_SERIAL_PORT_MSG_READY = 15;
	localparam int BIT_FIRST_SERIAL_PORT_MSG_END = 16;

	// ****************************************
	// Reset values and responses
	// ****************************************
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Port operating modes
	typedef enum logic [1:0] {MODE_GENERAL, MODE_COMMAND, MODE_LINK} port_mode_t;

	// Events reported by the first serial port and tool port engines
	typedef struct packed {
		logic tx_error;
		logic rx_terminator;
		logic tx_complete;
		logic tx_request;
	} port_events_t;

	// Message instruction status
	typedef struct packed {
		logic busy;
		logic abnormal;
		logic [15:0] error_code;
		logic [15:0] end_code;
	} msg_status_t;

endpackage

//--- tb/scan_model.sv
// Scan boundary model of the controller program that polls the flags
`timescale 1ns/1ns
`default_nettype none

module scan_model
#(
	parameter int SCAN_CYCLES = 16
)
(
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	output logic scan_start // One-cycle scan boundary
);
	int cnt = 0;

	// Flags may move mid-scan, so the program re-reads them
	always_ff @(posedge aclk)
	begin
		cnt <= (!aresetn || cnt == SCAN_CYCLES - 1) ? 0 : cnt + 1;
		scan_start <= aresetn && cnt == SCAN_CYCLES - 1;
	end
endmodule

`default_nettype wire

//--- tb/serial_port_status_flags_tb_top.sv
// Self-checking testbench of the status flag bank
`timescale 1ns/1ns
`default_nettype none

module serial_port_status_flags_tb_top;
	import flag_bank_pkg::*;
	logic aclk = 0, aresetn = 0, scan_start, rewrite_complete = 0, print_active = 0;
	logic first_serial_port_msg_done = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, sticky = 0, lf = 32'h02BA178D;
	logic [3:0] s_axi_wstrb = 0, counter_active = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	port_mode_t first_serial_port_mode = MODE_COMMAND, tool_mode = MODE_COMMAND, second_serial_port_mode = MODE_COMMAND;
	port_events_t first_serial_port_events = '0, tool_events = '0;
	msg_status_t first_serial_port_msg = 34'h200000000;
	int mismatches = 0, checks_done = 0;

	flag_bank u_flag_bank (.aclk, .aresetn, .scan_start, .rewrite_complete, .print_active,
		.first_serial_port_mode, .tool_mode, .second_serial_port_mode, .first_serial_port_events, .tool_events, .counter_active,
		.first_serial_port_msg, .first_serial_port_msg_done, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	scan_model u_scan_model (.aclk(aclk), .aresetn(aresetn), .scan_start(scan_start));

	initial
	begin
		forever #2 aclk = ~aclk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] exp_flags();
		logic [31:0] w;
		w = sticky;
		w[BIT_FIRST_SERIAL_PORT_MODE] = first_serial_port_mode == MODE_GENERAL;
		w[BIT_PRINT_BUSY] = print_active;
		w[BIT_COUNTER0 +: 4] = counter_active;
		w[BIT_TOOL_MODE] = tool_mode == MODE_GENERAL;
		w[BIT_FIRST_SERIAL_PORT_LINK] = first_serial_port_mode == MODE_LINK;
		w[BIT_SECOND_SERIAL_PORT_MODE] = second_serial_port_mode == MODE_GENERAL;
		w[BIT_FIRST_SERIAL_PORT_MSG_READY] = !first_serial_port_msg.busy;
		return w;
	endfunction

	// Entered just after a rising edge; ready is sampled mid-cycle, where it is settled
	task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		bit ta, tw, tb;
		logic [31:0] q;
		logic [1:0] r;
		n = 0;
		tb = 0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		while (!tb && n < 100)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = wr ? s_axi_bvalid : s_axi_rvalid;
			q = wr ? 32'h0 : s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			n++;
			@(posedge aclk);
			if (ta)
			begin
				s_axi_awvalid <= 0;
				s_axi_arvalid <= 0;
			end
			if (tw)
				s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		check({31'h0, tb}, 32'h1);
		check({30'h0, r}, {30'h0, a > OFS_SCRATCH ? RESP_SLVERR : RESP_OKAY});
		if (!wr)
			check(q, d);
		@(posedge aclk);
	endtask

	task automatic ev(input bit tool, input port_events_t e);
		int rx, tx;
		bit gen;
		rx = tool ? BIT_TOOL_RX_DONE : BIT_FIRST_SERIAL_PORT_RX_DONE;
		tx = tool ? BIT_TOOL_TX_DONE : BIT_FIRST_SERIAL_PORT_TX_DONE;
		first_serial_port_events <= tool ? 4'h0 : e;
		tool_events <= tool ? e : 4'h0;
		@(posedge aclk);
		// Done flags only react in general-purpose mode
		gen = tool ? (tool_mode == MODE_GENERAL) : (first_serial_port_mode == MODE_GENERAL);
		first_serial_port_events <= '0;
		tool_events <= '0;
		@(posedge aclk);
		sticky[tx] = gen & e.tx_complete | (sticky[tx] & !(gen & e.tx_request));
		sticky[rx] = sticky[rx] | (gen & e.rx_terminator);
		if (!tool)
			sticky[BIT_FIRST_SERIAL_PORT_ERROR] = e.tx_error | (sticky[BIT_FIRST_SERIAL_PORT_ERROR] & !e.tx_request);
		axi(0, OFS_FLAGS, exp_flags(), 0);
	endtask

	task automatic msg_fin(input logic ab, input logic [31:0] c);
		first_serial_port_msg <= {1'b0, ab, c};
		first_serial_port_msg_done <= 1;
		@(posedge aclk);
		first_serial_port_msg_done <= 0;
		@(posedge aclk);
		sticky[BIT_FIRST_SERIAL_PORT_MSG_END] = ab;
	endtask

	task automatic wait_scan();
		int n;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (!scan_start && n < 100);
		if (!scan_start)
			mismatches++;
		@(posedge aclk);
	endtask

	initial
	begin
		#60000;
		mismatches++;
		wrap_up();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		logic [27:0] evs;
		evs = 28'h1918412;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		axi(0, OFS_FLAGS, RESET_WORD, 0);
		axi(0, OFS_END_CODE, 32'h0, 0);
		$display("test reset done");
		for (int i = 0; i < 3; i++)
		begin
			first_serial_port_mode <= port_mode_t'(i);
			tool_mode <= port_mode_t'(i);
			second_serial_port_mode <= port_mode_t'(i);
			@(posedge aclk);
			axi(0, OFS_FLAGS, exp_flags(), 0);
		end
		for (int j = 0; j < 4; j++)
		begin
			first_serial_port_mode <= port_mode_t'(j >> 1);
			tool_mode <= port_mode_t'(j >> 1);
			for (int i = 0; i < 7; i++)
				ev(j[0], evs[4 * i +: 4]);
		end
		$display("test events done");
		for (int i = 0; i < 40; i++)
		begin
			lf = lfsr(lf);
			print_active <= lf[0];
			counter_active <= lf[4:1];
			first_serial_port_msg.busy <= lf[5];
			first_serial_port_mode <= port_mode_t'(lf[7:6] % 2'h3);
			tool_mode <= port_mode_t'(lf[9:8] % 2'h3);
			second_serial_port_mode <= port_mode_t'(lf[11:10] % 2'h3);
			@(posedge aclk);
			axi(0, OFS_FLAGS, exp_flags(), 0);
		end
		$display("test levels done");
		first_serial_port_msg.busy <= 0;
		@(posedge aclk);
		axi(0, OFS_FLAGS, exp_flags(), 0);
		first_serial_port_msg.busy <= 1;
		@(posedge aclk);
		axi(0, OFS_FLAGS, exp_flags(), 0);
		lf = lfsr(lf);
		msg_fin(1, lf);
		axi(0, OFS_FLAGS, exp_flags(), 0);
		axi(0, OFS_ERROR_CODE, {16'h0, lf[31:16]}, 0);
		axi(0, OFS_END_CODE, {16'h0, lf[15:0]}, 0);
		msg_fin(0, 32'h0);
		axi(0, OFS_FLAGS, exp_flags(), 0);
		$display("test message done");
		wait_scan();
		rewrite_complete <= 1;
		@(posedge aclk);
		rewrite_complete <= 0;
		axi(0, OFS_FLAGS, exp_flags(), 0);
		wait_scan();
		axi(0, OFS_FLAGS, exp_flags() | 32'h4, 0);
		wait_scan();
		axi(0, OFS_FLAGS, exp_flags(), 0);
		$display("test rewrite done");
		axi(1, OFS_FLAGS, 32'hFFFFFFFF, 4'hF);
		axi(1, OFS_ERROR_CODE, 32'hFFFFFFFF, 4'hF);
		axi(0, OFS_FLAGS, exp_flags(), 0);
		axi(0, OFS_ERROR_CODE, {16'h0, lf[31:16]}, 0);
		lf = lfsr(lf);
		axi(1, OFS_SCRATCH, lf, 4'h5);
		axi(0, OFS_SCRATCH, lf & 32'h00FF00FF, 0);
		axi(1, 8'h10, lf, 4'hF);
		axi(0, 8'h10, 32'h0, 0);
		$display("test registers done");
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		sticky = 0;
		axi(0, OFS_FLAGS, exp_flags(), 0);
		axi(0, OFS_SCRATCH, RESET_WORD, 0);
		$display("test second reset done");
		wrap_up();
	end
endmodule

`default_nettype wire
